/* src/fra_pkg.sv */
package fra_pkg;
  // command codes of the register bank
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STATUS_MFR = 8'h80;
  localparam logic [7:0] CMD_FAULT_UNITS = 8'hc8;
  localparam logic [7:0] CMD_BUS_CFG = 8'hc9;
  localparam logic [7:0] CMD_OC_RESP = 8'hca;
  // widths
  localparam int DATA_W = 34;
  localparam int UNIT_W = 2;
  localparam int UMS_W = 9;
  localparam int TMR_W = 16;
  // delay unit code fields
  localparam int VOUT_UNIT_LSB = 6;
  localparam int VIN_UNIT_LSB = 4;
  localparam int IOUT_UNIT_LSB = 2;
  localparam int TEMP_UNIT_LSB = 0;
  // bus configuration fields
  localparam int BASE_LSB = 24;
  localparam int BASE_W = 8;
  localparam int OFS_LSB = 17;
  localparam int OFS_W = 7;
  localparam int RES_EN_BIT = 16;
  localparam int CTRL_POL_BIT = 32;
  localparam int PG_POL_BIT = 33;
  // overcurrent response fields
  localparam int RESP_LSB = 6;
  localparam int RESP_W = 2;
  localparam int RETRY_LSB = 3;
  localparam int CNT_W = 3;
  localparam int DLY_LSB = 0;
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_RETRY = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_ENDLESS = 3'h7;
  // status bit of fast overcurrent in the status word
  localparam int STAT_OC_FAST_BIT = 5;
  // delay units in milliseconds
  localparam logic [8:0] UNIT_MS_0 = 9'h001;
  localparam logic [8:0] UNIT_MS_1 = 9'h004;
  localparam logic [8:0] UNIT_MS_2 = 9'h010;
  localparam logic [8:0] UNIT_MS_3 = 9'h100;
  // reset values
  localparam logic [7:0] RST_FAULT_UNITS = 8'h00;
  localparam logic [33:0] RST_BUS_CFG = 34'h000000000;
  localparam logic [7:0] RST_OC_RESP = 8'h00;
  // millisecond tick timing
  localparam int MS_NS = 1000000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  // fast overcurrent response states
  typedef enum logic [1:0] {ST_RUN, ST_LIMIT, ST_GAP, ST_LATCH} fra_oc_st_t;
endpackage

/* src/fra_tmr_if.sv */
`timescale 1ns/1ps
// link between the response logic and the delay timer
interface fra_tmr_if;
  logic start; // one-cycle load pulse
  logic [15:0] ms_target; // delay in milliseconds
  logic done; // one-cycle expiry pulse
  logic busy; // timer running
  modport ctl (output start, output ms_target, input done, input busy);
  modport tmr (input start, input ms_target, output done, output busy);
endinterface

/* src/fra_tick.sv */
`timescale 1ns/1ps
module fra_tick #(
  parameter int CYC_PER_MS = fra_pkg::CYC_PER_MS
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // timer link
  fra_tmr_if.tmr t
);
  // timer state
  typedef struct packed {
    logic [15:0] pre; // cycles inside current millisecond
    logic [15:0] ms_left; // milliseconds still to run
    logic busy; // counting
    logic done; // expiry pulse
  } fra_tick_t;
  fra_tick_t r, n;
  logic ms_tick; // end of one millisecond
  assign ms_tick = (r.pre == 16'(CYC_PER_MS - 1));
  // next state of the timer
  always_comb begin
    n = r;
    n.done = 1'b0;
    if (t.start) begin
      // restart always wins over a running count
      n.pre = 16'h0000;
      n.ms_left = t.ms_target;
      n.busy = 1'b1;
    end else if (r.busy) begin
      n.pre = ms_tick ? 16'h0000 : r.pre + 16'h0001;
      if (ms_tick) begin
        n.ms_left = r.ms_left - 16'h0001;
        if (r.ms_left == 16'h0001) begin
          n.busy = 1'b0;
          n.done = 1'b1;
        end
      end
    end
  end
  // state register
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  assign t.done = r.done;
  assign t.busy = r.busy;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // expiry only after the last millisecond finished
  AST_TMR_DONE: assert property (r.busy && !t.start && ms_tick && r.ms_left == 16'h0001
    |=> r.done && !r.busy) else $error("timer missed expiry");
  // no expiry without a running count
  AST_TMR_QUIET: assert property (!r.busy && !t.start |=> !r.done)
    else $error("timer expired while idle");
endmodule

/* src/fra_top.sv */
`timescale 1ns/1ps
// What this block does
// - vout delay unit from bits 7:6
// - vin delay unit from bits 5:4
// - output_current_delay_unit from bits 3:2
// - temperature delay unit from bits 1:0
// - base address in bits 31:24, offset added
// - programmed offset bits 23:17 when resistor off
// - bit 16 selects resistor offset
// - bit 33 sets power-good output polarity
// - bit 32 sets control input polarity
// - fast overcurrent sets status and alerts host
// - code 00: limit current, run forever
// - code 11: limit for delay, then retry
// - bits 5:3 give restart count, 7 endless
// - zero retries: output off until cleared
// - bits 2:0 give delay units, 1 << code
// - delay times run-on and restart gap
module fra_top #(
  parameter int CYC_PER_MS = fra_pkg::CYC_PER_MS
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // decoded command port
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [33:0] cmd_wdata_i,
  output logic [33:0] cmd_rdata_o,
  output logic cmd_rvalid_o,
  output logic cmd_nack_o,
  // strap and converter inputs
  input wire logic [6:0] strap_offset_i,
  input wire logic ctrl_pin_i,
  input wire logic power_good_i,
  input wire logic oc_fast_i,
  // converter outputs
  output logic [7:0] bus_addr_o,
  output logic power_good_o,
  output logic output_enable_o,
  output logic current_limit_o,
  // host notification
  output logic oc_fast_flag_o,
  output logic alert_o,
  // delay units in milliseconds per fault class
  output logic [8:0] vout_unit_ms_o,
  output logic [8:0] vin_unit_ms_o,
  output logic [8:0] iout_unit_ms_o,
  output logic [8:0] temp_unit_ms_o
);
  // whole state of the block
  typedef struct packed {
    logic [7:0] faults; // delay unit register
    logic [33:0] buscfg; // address and pin register
    logic [7:0] ocresp; // fast overcurrent response register
    logic [6:0] strap; // captured strap offset
    logic strap_done; // strap captured once
    fra_pkg::fra_oc_st_t st; // response state
    logic [2:0] left; // restarts still allowed
    logic oc_prev; // last overcurrent level
    logic flag; // sticky fast overcurrent status
    logic alert; // alert to host
    logic [7:0] addr; // bus address
    logic pg; // power-good pin level
    logic en; // output enable
    logic limit; // current limiting active
    logic [33:0] rdata; // read answer
    logic rvalid; // read answer pulse
    logic nack; // refused command pulse
    logic start; // timer load pulse
    logic [15:0] target; // timer load value
    logic [8:0] vout_u; // vout unit
    logic [8:0] vin_u; // vin unit
    logic [8:0] iout_u; // iout unit
    logic [8:0] temp_u; // temperature unit
  } fra_st_t;
  fra_st_t r, n;
  fra_tmr_if tmr ();
  // delay timer
  fra_tick #(.CYC_PER_MS(CYC_PER_MS)) u_tick (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .t(tmr.tmr)
  );
  assign tmr.start = r.start;
  assign tmr.ms_target = r.target;
  // unit code to milliseconds
  function automatic logic [8:0] unit_ms(input logic [1:0] code);
    case (code)
      2'h0: unit_ms = fra_pkg::UNIT_MS_0;
      2'h1: unit_ms = fra_pkg::UNIT_MS_1;
      2'h2: unit_ms = fra_pkg::UNIT_MS_2;
      default: unit_ms = fra_pkg::UNIT_MS_3;
    endcase
  endfunction
  // decoded helpers
  logic rise; // new fast overcurrent event
  logic clr_cmd; // clear faults command
  logic ctrl_on; // control input asserted
  logic [1:0] resp; // response code
  logic [2:0] retries; // retry setting
  logic [15:0] dly_ms; // delay in milliseconds
  logic [15:0] units; // delay in units
  assign rise = oc_fast_i && !r.oc_prev;
  assign clr_cmd = cmd_valid_i && cmd_write_i && (cmd_code_i == fra_pkg::CMD_CLEAR_FAULTS);
  assign ctrl_on = r.buscfg[fra_pkg::CTRL_POL_BIT] ? ctrl_pin_i : !ctrl_pin_i;
  assign resp = r.ocresp[fra_pkg::RESP_LSB +: fra_pkg::RESP_W];
  assign retries = r.ocresp[fra_pkg::RETRY_LSB +: fra_pkg::CNT_W];
  assign units = 16'h0001 << r.ocresp[fra_pkg::DLY_LSB +: fra_pkg::CNT_W];
  assign dly_ms = units * 16'(r.iout_u);
  // next state
  always_comb begin
    n = r;
    n.rvalid = 1'b0;
    n.nack = 1'b0;
    n.start = 1'b0;
    n.oc_prev = oc_fast_i;
    // strap taken on the first edge after reset release
    if (!r.strap_done) begin
      n.strap = strap_offset_i;
      n.strap_done = 1'b1;
    end
    // command decode
    if (cmd_valid_i) begin
      case (cmd_code_i)
        fra_pkg::CMD_FAULT_UNITS: begin
          if (cmd_write_i) begin
            n.faults = cmd_wdata_i[7:0];
          end else begin
            n.rdata = {26'h0000000, r.faults};
            n.rvalid = 1'b1;
          end
        end
        fra_pkg::CMD_BUS_CFG: begin
          if (cmd_write_i) begin
            n.buscfg = cmd_wdata_i;
          end else begin
            n.rdata = r.buscfg;
            n.rvalid = 1'b1;
          end
        end
        fra_pkg::CMD_OC_RESP: begin
          if (cmd_write_i) begin
            n.ocresp = cmd_wdata_i[7:0];
            n.left = cmd_wdata_i[fra_pkg::RETRY_LSB +: fra_pkg::CNT_W];
          end else begin
            n.rdata = {26'h0000000, r.ocresp};
            n.rvalid = 1'b1;
          end
        end
        fra_pkg::CMD_STATUS_MFR: begin
          // status is read only
          if (cmd_write_i) begin
            n.nack = 1'b1;
          end else begin
            n.rdata = '0;
            n.rdata[fra_pkg::STAT_OC_FAST_BIT] = r.flag;
            n.rvalid = 1'b1;
          end
        end
        fra_pkg::CMD_CLEAR_FAULTS: begin
          // clear releases a latched-off output
          if (cmd_write_i) begin
            n.flag = 1'b0;
            n.alert = 1'b0;
            n.left = retries;
            if (r.st == fra_pkg::ST_LATCH) begin
              n.st = fra_pkg::ST_RUN;
            end
          end else begin
            n.nack = 1'b1;
          end
        end
        default: begin
          // unmapped code
          n.nack = 1'b1;
        end
      endcase
    end
    // event set after the clear so it wins
    if (rise) begin
      n.flag = 1'b1;
      n.alert = 1'b1;
    end
    // fast overcurrent response
    case (r.st)
      fra_pkg::ST_RUN: begin
        if (oc_fast_i && resp == fra_pkg::RESP_RETRY) begin
          n.st = fra_pkg::ST_LIMIT;
          n.start = 1'b1;
          n.target = dly_ms;
        end
      end
      fra_pkg::ST_LIMIT: begin
        if (tmr.done) begin
          if (!oc_fast_i) begin
            // fault gone, full retry budget again
            n.st = fra_pkg::ST_RUN;
            n.left = retries;
          end else if (retries == fra_pkg::RETRY_NONE) begin
            n.st = fra_pkg::ST_LATCH;
          end else if (retries != fra_pkg::RETRY_ENDLESS && r.left == 3'h0) begin
            n.st = fra_pkg::ST_LATCH;
          end else begin
            // restart after the gap
            n.st = fra_pkg::ST_GAP;
            n.start = 1'b1;
            n.target = dly_ms;
            if (retries != fra_pkg::RETRY_ENDLESS) begin
              n.left = r.left - 3'h1;
            end
          end
        end
      end
      fra_pkg::ST_GAP: begin
        if (tmr.done) begin
          n.st = fra_pkg::ST_RUN;
        end
      end
      fra_pkg::ST_LATCH: begin
        // leave only through the clear command
      end
      default: begin
        n.st = fra_pkg::ST_RUN;
      end
    endcase
    // registered pin and configuration outputs
    n.addr = n.buscfg[fra_pkg::BASE_LSB +: fra_pkg::BASE_W]
      + {1'b0, (n.buscfg[fra_pkg::RES_EN_BIT] ? n.strap
      : n.buscfg[fra_pkg::OFS_LSB +: fra_pkg::OFS_W])};
    n.pg = n.buscfg[fra_pkg::PG_POL_BIT] ? power_good_i : !power_good_i;
    n.en = ctrl_on && (n.st == fra_pkg::ST_RUN || n.st == fra_pkg::ST_LIMIT);
    n.limit = oc_fast_i && (n.st == fra_pkg::ST_RUN || n.st == fra_pkg::ST_LIMIT);
    n.vout_u = unit_ms(n.faults[fra_pkg::VOUT_UNIT_LSB +: fra_pkg::UNIT_W]);
    n.vin_u = unit_ms(n.faults[fra_pkg::VIN_UNIT_LSB +: fra_pkg::UNIT_W]);
    n.iout_u = unit_ms(n.faults[fra_pkg::IOUT_UNIT_LSB +: fra_pkg::UNIT_W]);
    n.temp_u = unit_ms(n.faults[fra_pkg::TEMP_UNIT_LSB +: fra_pkg::UNIT_W]);
  end
  // state register, constants only under reset
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
      r.faults <= fra_pkg::RST_FAULT_UNITS;
      r.buscfg <= fra_pkg::RST_BUS_CFG;
      r.ocresp <= fra_pkg::RST_OC_RESP;
      r.st <= fra_pkg::ST_RUN;
      r.vout_u <= fra_pkg::UNIT_MS_0;
      r.vin_u <= fra_pkg::UNIT_MS_0;
      r.iout_u <= fra_pkg::UNIT_MS_0;
      r.temp_u <= fra_pkg::UNIT_MS_0;
    end else begin
      r <= n;
    end
  end
  // outputs straight from the state register
  assign cmd_rdata_o = r.rdata;
  assign cmd_rvalid_o = r.rvalid;
  assign cmd_nack_o = r.nack;
  assign bus_addr_o = r.addr;
  assign power_good_o = r.pg;
  assign output_enable_o = r.en;
  assign current_limit_o = r.limit;
  assign oc_fast_flag_o = r.flag;
  assign alert_o = r.alert;
  assign vout_unit_ms_o = r.vout_u;
  assign vin_unit_ms_o = r.vin_u;
  assign iout_unit_ms_o = r.iout_u;
  assign temp_unit_ms_o = r.temp_u;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  AST_VOUT_UNIT: assert property (r.faults[7:6] == 2'h3 |-> vout_unit_ms_o == 9'h100)
    else $error("vout unit not 256 ms");
  AST_VIN_UNIT: assert property (r.faults[5:4] == 2'h1 |-> vin_unit_ms_o == 9'h004)
    else $error("vin unit not 4 ms");
  AST_IOUT_UNIT: assert property (r.faults[3:2] == 2'h2 |-> iout_unit_ms_o == 9'h010)
    else $error("iout unit not 16 ms");
  AST_TEMP_UNIT: assert property (r.faults[1:0] == 2'h0 |-> temp_unit_ms_o == 9'h001)
    else $error("temperature unit not 1 ms");
  AST_ADDR_PROG: assert property (!r.buscfg[16] |-> bus_addr_o == r.buscfg[31:24] + {1'b0, r.buscfg[23:17]})
    else $error("programmed address wrong");
  AST_ADDR_STRAP: assert property (r.buscfg[16] |-> bus_addr_o == r.buscfg[31:24] + {1'b0, r.strap})
    else $error("strap address wrong");
  AST_PG_POL: assert property (##1 power_good_o == (r.buscfg[33] ? $past(power_good_i) : !$past(power_good_i)))
    else $error("power-good polarity wrong");
  AST_CTRL_POL: assert property (output_enable_o |-> $past(r.buscfg[32]) == $past(ctrl_pin_i))
    else $error("enable against control polarity");
  AST_FLAG_SET: assert property (rise |=> oc_fast_flag_o && alert_o)
    else $error("fault not flagged");
  AST_IGNORE_RUN: assert property (resp == 2'h0 && r.st == fra_pkg::ST_RUN && oc_fast_i && !cmd_valid_i
    |=> r.st == fra_pkg::ST_RUN && current_limit_o) else $error("ignore mode did not limit");
  AST_LIMIT_ENTER: assert property (r.st == fra_pkg::ST_RUN && resp == 2'h3 && oc_fast_i
    |=> r.st == fra_pkg::ST_LIMIT && tmr.start ##0 tmr.ms_target == $past(dly_ms))
    else $error("limit period not started");
  AST_ENDLESS: assert property (r.st == fra_pkg::ST_LIMIT && tmr.done && oc_fast_i && retries == 3'h7
    |=> r.st == fra_pkg::ST_GAP && !output_enable_o) else $error("endless retry stopped");
  AST_LATCH_HOLD: assert property (r.st == fra_pkg::ST_LATCH && !clr_cmd
    |=> r.st == fra_pkg::ST_LATCH && !output_enable_o) else $error("latched output released");
  AST_UNITS: assert property (r.ocresp[2:0] == 3'h7 |-> units == 16'h0080)
    else $error("delay count not 128 units");
  // response machine, status and strap checks
  // status read returns the sticky fast overcurrent bit
  AST_STATUS_READ: assert property (cmd_valid_i && !cmd_write_i
    && cmd_code_i == fra_pkg::CMD_STATUS_MFR
    |=> cmd_rvalid_o && cmd_rdata_o[fra_pkg::STAT_OC_FAST_BIT] == $past(r.flag))
    else $error("status bit not returned");
  // flag stays until the clear command
  AST_FLAG_HOLD: assert property (oc_fast_flag_o && !clr_cmd |=> oc_fast_flag_o)
    else $error("fault flag dropped without clear");
  // clear without a new event empties flag and alert
  AST_CLEAR_FLAG: assert property (clr_cmd && !rise |=> !oc_fast_flag_o && !alert_o)
    else $error("clear left the flag set");
  // clear releases a latched-off output
  AST_LATCH_CLEAR: assert property (r.st == fra_pkg::ST_LATCH && clr_cmd
    |=> r.st == fra_pkg::ST_RUN) else $error("clear did not release latch");
  // zero retries latch off at the end of the limit period
  AST_NO_RETRY: assert property (r.st == fra_pkg::ST_LIMIT && tmr.done && oc_fast_i
    && retries == fra_pkg::RETRY_NONE |=> r.st == fra_pkg::ST_LATCH && !output_enable_o)
    else $error("zero retries did not latch");
  // spent budget latches off as well
  AST_BUDGET_OUT: assert property (r.st == fra_pkg::ST_LIMIT && tmr.done && oc_fast_i
    && retries != fra_pkg::RETRY_ENDLESS && r.left == 3'h0 |=> r.st == fra_pkg::ST_LATCH)
    else $error("retry budget overrun");
  // a restart loads the same delay for the gap
  AST_GAP_TIMER: assert property (r.st == fra_pkg::ST_LIMIT && tmr.done && oc_fast_i
    && retries != fra_pkg::RETRY_NONE && (retries == fra_pkg::RETRY_ENDLESS || r.left != 3'h0)
    |=> r.st == fra_pkg::ST_GAP && tmr.start && tmr.ms_target == $past(dly_ms))
    else $error("restart gap not timed");
  // output off and no limiting during the gap
  AST_GAP_OFF: assert property (r.st == fra_pkg::ST_GAP
    |-> !output_enable_o && !current_limit_o) else $error("output on during restart gap");
  // gap end restarts the converter
  AST_GAP_RESTART: assert property (r.st == fra_pkg::ST_GAP && tmr.done
    |=> r.st == fra_pkg::ST_RUN) else $error("no restart after gap");
  // limit period ending with the fault gone goes back to run
  AST_FAULT_GONE: assert property (r.st == fra_pkg::ST_LIMIT && tmr.done && !oc_fast_i
    |=> r.st == fra_pkg::ST_RUN) else $error("cleared fault not resumed");
  // two units of 4 ms make an 8 ms delay
  AST_DLY_MS: assert property (r.faults[3:2] == 2'h1 && r.ocresp[2:0] == 3'h1
    |-> dly_ms == 16'h0008) else $error("delay not in iout units");
  // codes 01 and 10 never leave run
  AST_RESP_MID: assert property ((resp == 2'h1 || resp == 2'h2)
    && r.st == fra_pkg::ST_RUN
    |=> r.st == fra_pkg::ST_RUN) else $error("middle response code retried");
  // strap offset taken once and then kept
  AST_STRAP_HOLD: assert property (r.strap_done |=> $stable(r.strap))
    else $error("strap offset changed");
  // code 0 is one unit
  AST_UNITS_ZERO: assert property (r.ocresp[2:0] == 3'h0 |-> units == 16'h0001)
    else $error("delay count not one unit");
endmodule

/* test/fra_host.sv */
`timescale 1ns/1ps
// host side of the decoded command port
module fra_host (
  // clock
  input wire logic clock_i,
  // command request
  output logic cmd_valid_o,
  output logic cmd_write_o,
  output logic [7:0] cmd_code_o,
  output logic [33:0] cmd_wdata_o,
  // answer
  input wire logic [33:0] cmd_rdata_i,
  input wire logic cmd_rvalid_i,
  input wire logic cmd_nack_i
);
  // idle request lines from time zero
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_code_o = 8'h00;
    cmd_wdata_o = 34'h0;
  end
  // one request held over its taking edge, answer awaited briefly
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [33:0] wd,
                      output logic [33:0] rd, output logic nk);
    int i;
    @(posedge clock_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_write_o = wr;
    cmd_code_o = code;
    cmd_wdata_o = wd;
    @(posedge clock_i);
    #1;
    cmd_valid_o = 1'b0;
    // released data must not keep its last value
    cmd_wdata_o = ~wd;
    cmd_code_o = ~code;
    for (i = 0; i < 3; i++) begin
      if (cmd_rvalid_i === 1'b1 || cmd_nack_i === 1'b1) break;
      @(posedge clock_i);
      #1;
    end
    rd = cmd_rdata_i;
    nk = cmd_nack_i;
  endtask
endmodule

/* test/fra_top_tb.sv */
`timescale 1ns/1ps
// bench of the fault delay and bus configuration bank
module fra_top_tb;
  // short millisecond keeps delays cheap
  localparam int CPM = 10;
  // one row: register values and the outputs they give
  typedef struct packed {
    logic [7:0] fu;
    logic [33:0] cfg;
    logic [7:0] addr;
    logic pg;
    logic oe;
  } fra_row_t;
  logic clock;
  logic rst = 1'b1;
  logic oc = 1'b0;
  logic ctl = 1'b1;
  logic pgi = 1'b1;
  logic valid, write, nack, rvalid, flag, alert, climit, pg, oe, nk;
  logic [7:0] code, addr;
  logic [33:0] wdata, rdata, v;
  logic [8:0] u_vo, u_vi, u_io, u_te;
  int fails = 0;
  int checks_done = 0;
  int n;
  // strap offset is 7'h15, power good and control pin high
  fra_row_t rows [4] = '{
    '{8'h00, 34'h3400a0000, 8'h45, 1'b1, 1'b1},
    '{8'he4, 34'h0400b0000, 8'h55, 1'b0, 1'b0},
    '{8'h1b, 34'h2f0fe0000, 8'h6f, 1'b1, 1'b0},
    '{8'h55, 34'h100000000, 8'h00, 1'b0, 1'b1}};
  logic [7:0] regs [3] = '{fra_pkg::CMD_FAULT_UNITS, fra_pkg::CMD_BUS_CFG, fra_pkg::CMD_OC_RESP};
  // refused requests: write flag and code
  logic [8:0] bad [3] = '{9'h055, {1'b1, fra_pkg::CMD_STATUS_MFR}, {1'b0, fra_pkg::CMD_CLEAR_FAULTS}};

  fra_top #(.CYC_PER_MS(CPM)) u_fra_top (
    .clock_i(clock), .rst_i(rst), .cmd_valid_i(valid), .cmd_write_i(write),
    .cmd_code_i(code), .cmd_wdata_i(wdata), .cmd_rdata_o(rdata), .cmd_rvalid_o(rvalid),
    .cmd_nack_o(nack), .strap_offset_i(7'h15), .ctrl_pin_i(ctl), .power_good_i(pgi),
    .oc_fast_i(oc), .bus_addr_o(addr), .power_good_o(pg), .output_enable_o(oe),
    .current_limit_o(climit), .oc_fast_flag_o(flag), .alert_o(alert),
    .vout_unit_ms_o(u_vo), .vin_unit_ms_o(u_vi), .iout_unit_ms_o(u_io), .temp_unit_ms_o(u_te));
  fra_host u_fra_host (
    .clock_i(clock), .cmd_valid_o(valid), .cmd_write_o(write), .cmd_code_o(code),
    .cmd_wdata_o(wdata), .cmd_rdata_i(rdata), .cmd_rvalid_i(rvalid), .cmd_nack_i(nack));

  // 100 ns clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // milliseconds per unit for a two-bit code
  function automatic logic [8:0] unit(input logic [1:0] c);
    case (c)
      2'h0: return 9'h001;
      2'h1: return 9'h004;
      2'h2: return 9'h010;
      default: return 9'h100;
    endcase
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    checks_done++;
    if (g < lo || g > hi) begin
      fails++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [33:0] d);
    u_fra_host.xfer(1'b1, c, d, v, nk);
  endtask
  task automatic rd(input logic [7:0] c);
    u_fra_host.xfer(1'b0, c, 34'h0, v, nk);
  endtask
  // cycles for which the output enable stays at one level
  task automatic runlen(input logic lvl);
    n = 0;
    while (oe === lvl && n < 2000) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic do_reset();
    rst = 1'b1;
    cyc(20);
    rst = 1'b0;
    cyc(2);
  endtask
  task automatic clear();
    oc = 1'b0;
    wr(fra_pkg::CMD_CLEAR_FAULTS, 34'h0);
    cyc(2);
  endtask
  task automatic results();
    if (fails == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // watchdog well past the expected run
  initial begin
    #2000000;
    fails++;
    results();
  end

  // main sequence
  initial begin
    do_reset();
    chk("units_at_reset", {4{9'h001}}, {u_vo, u_vi, u_io, u_te});
    chk("pg_at_reset", 1'b0, pg);
    foreach (regs[i]) begin
      rd(regs[i]);
      chk("reset_value", 36'h0, v);
      chk("read_answer", 1'b1, rvalid);
    end
    foreach (bad[i]) begin
      u_fra_host.xfer(bad[i][8], bad[i][7:0], 34'h0, v, nk);
      chk("nack", 1'b1, nk);
    end
    // table of unit codes, addresses and polarities
    foreach (rows[i]) begin
      wr(fra_pkg::CMD_FAULT_UNITS, {26'h0, rows[i].fu});
      wr(fra_pkg::CMD_BUS_CFG, rows[i].cfg);
      rd(fra_pkg::CMD_BUS_CFG);
      chk("bus_cfg", rows[i].cfg, v);
      rd(fra_pkg::CMD_FAULT_UNITS);
      chk("unit_reg", rows[i].fu, v);
      chk("vout_unit", unit(rows[i].fu[7:6]), u_vo);
      chk("vin_unit", unit(rows[i].fu[5:4]), u_vi);
      chk("iout_unit", unit(rows[i].fu[3:2]), u_io);
      chk("temp_unit", unit(rows[i].fu[1:0]), u_te);
      chk("bus_addr", rows[i].addr, addr);
      chk("power_good", rows[i].pg, pg);
      chk("output_enable", rows[i].oe, oe);
    end
    // pin inputs low under the last row's polarities
    ctl = 1'b0;
    pgi = 1'b0;
    cyc(2);
    chk("ctrl_low_off", 1'b0, oe);
    chk("pg_low_active", 1'b1, pg);
    ctl = 1'b1;
    pgi = 1'b1;
    cyc(2);
    // ignore code: flag, alert and limiting, output stays on
    wr(fra_pkg::CMD_OC_RESP, 34'h0);
    oc = 1'b1;
    cyc(2);
    chk("flag_alert", 2'h3, {flag, alert});
    chk("limit", 1'b1, climit);
    cyc(100);
    chk("on_while_limiting", 1'b1, oe);
    rd(fra_pkg::CMD_STATUS_MFR);
    chk("status_bit", 1'b1, v[fra_pkg::STAT_OC_FAST_BIT]);
    clear();
    chk("flag_cleared", 2'h0, {flag, alert});
    // code 01 acts like ignore: no limit period, no latch
    wr(fra_pkg::CMD_OC_RESP, 34'h040);
    oc = 1'b1;
    cyc(60);
    chk("mid_code_runs", 2'h3, {oe, climit});
    clear();
    // no retry, one unit of 4 ms: latched off until cleared
    wr(fra_pkg::CMD_OC_RESP, 34'h0c0);
    oc = 1'b1;
    runlen(1'b1);
    chk_rng("limit_time", 4 * CPM, 4 * CPM + 4, n);
    oc = 1'b0;
    cyc(60);
    chk("latched_off", 1'b0, oe);
    clear();
    chk("on_after_clear", 1'b1, oe);
    // one retry, two units: limit, gap, limit, then off
    wr(fra_pkg::CMD_OC_RESP, 34'h0c9);
    oc = 1'b1;
    runlen(1'b1);
    chk_rng("limit_two_units", 8 * CPM, 8 * CPM + 4, n);
    runlen(1'b0);
    chk_rng("restart_gap", 8 * CPM, 8 * CPM + 4, n);
    runlen(1'b1);
    chk_rng("second_limit", 8 * CPM, 8 * CPM + 4, n);
    cyc(200);
    chk("retries_spent", 1'b0, oe);
    clear();
    // endless retries keep restarting
    wr(fra_pkg::CMD_OC_RESP, 34'h0f8);
    oc = 1'b1;
    repeat (3) begin
      runlen(1'b1);
      runlen(1'b0);
      chk_rng("endless_gap", 4 * CPM, 4 * CPM + 4, n);
    end
    oc = 1'b0;
    cyc(60);
    chk("fault_gone_runs", 1'b1, oe);
    // second reset mid-run
    do_reset();
    rd(fra_pkg::CMD_BUS_CFG);
    chk("cfg_after_reset", 36'h0, v);
    results();
  end
endmodule
